// >>> hw/prdc_endpoint.sv
`timescale 1ns/10ps
`default_nettype none
module prdc_endpoint (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic en_i,
  prdc_link_if.ep link,
  input wire logic fault_valid_i,
  input wire logic [prdc_pkg::IDX_W-1:0] fault_index_i,
  input wire logic [prdc_pkg::ASID_W-1:0] fault_asid_i,
  input wire logic fault_last_i,
  output logic fault_ready_o,
  input wire logic term_i,
  input wire logic term_all_i,
  input wire logic [prdc_pkg::ASID_W-1:0] term_asid_i,
  input wire logic [prdc_pkg::ASID_W-1:0] qry_asid_i,
  output logic qry_busy_o,
  output logic [prdc_pkg::SLOT_W:0] credits_o,
  output logic resp_valid_o,
  output logic [prdc_pkg::IDX_W-1:0] resp_index_o,
  output logic [prdc_pkg::ASID_W-1:0] resp_asid_o,
  output logic [prdc_pkg::CODE_W-1:0] resp_code_o
);
  import prdc_pkg::*;

  logic [CREDITS-1:0] v_r, v_nxt;
  logic [IDX_W-1:0] idx_r [CREDITS];
  logic [IDX_W-1:0] idx_nxt [CREDITS];
  logic [ASID_W-1:0] asid_r [CREDITS];
  logic [ASID_W-1:0] asid_nxt [CREDITS];
  logic inv_r, inv_nxt;
  logic up_v_r, up_v_nxt, up_t_r, up_t_nxt, up_l_r, up_l_nxt;
  logic [IDX_W-1:0] up_i_r, up_i_nxt;
  logic [ASID_W-1:0] up_a_r, up_a_nxt;
  logic rv_r, rv_nxt;
  logic [IDX_W-1:0] ri_r, ri_nxt;
  logic [ASID_W-1:0] ra_r, ra_nxt;
  logic [CODE_W-1:0] rc_r, rc_nxt;
  logic hit, found, busy;
  logic [SLOT_W-1:0] slot;
  logic [SLOT_W:0] nfree;

  always_comb begin
    v_nxt = v_r;
    idx_nxt = idx_r;
    asid_nxt = asid_r;
    inv_nxt = inv_r;
    up_v_nxt = 1'b0;
    up_t_nxt = up_t_r;
    up_i_nxt = up_i_r;
    up_a_nxt = up_a_r;
    up_l_nxt = up_l_r;
    rv_nxt = 1'b0;
    ri_nxt = ri_r;
    ra_nxt = ra_r;
    rc_nxt = rc_r;
    hit = 1'b0;
    found = 1'b0;
    busy = 1'b0;
    slot = '0;
    nfree = '0;
    for (int i = 0; i < CREDITS; i++) begin
      if (!v_r[i]) begin
        nfree = nfree + 1'b1;
        if (!found) begin
          found = 1'b1;
          slot = SLOT_W'(i);
        end
      end
      if (v_r[i] && asid_r[i] == qry_asid_i) begin
        busy = 1'b1;
      end
    end
    if (link.dn_valid && link.dn_type == DN_RESP) begin
      for (int i = 0; i < CREDITS; i++) begin
        if (v_r[i] && idx_r[i] == link.dn_index && asid_r[i] == link.dn_asid) begin
          v_nxt[i] = 1'b0;
          hit = 1'b1;
        end
      end
      // no match: nothing at all happens
      if (hit) begin
        rv_nxt = 1'b1;
        ri_nxt = link.dn_index;
        ra_nxt = link.dn_asid;
        rc_nxt = link.dn_code;
      end
    end
    if (term_i) begin
      for (int i = 0; i < CREDITS; i++) begin
        if (v_r[i] && (term_all_i || asid_r[i] == term_asid_i)) begin
          v_nxt[i] = 1'b0;
        end
      end
    end
    // faults win the egress so completions always trail them
    if (fault_valid_i && found) begin
      up_v_nxt = 1'b1;
      up_t_nxt = UP_PREQ;
      up_i_nxt = fault_index_i;
      up_a_nxt = fault_asid_i;
      up_l_nxt = fault_last_i;
      v_nxt[slot] = 1'b1;
      idx_nxt[slot] = fault_index_i;
      asid_nxt[slot] = fault_asid_i;
    end else if (inv_r) begin
      up_v_nxt = 1'b1;
      up_t_nxt = UP_ICPL;
      up_l_nxt = 1'b0;
      inv_nxt = 1'b0;
    end
    // served even mid-terminal; back-to-back requests merge only while faults hold the pending completion back
    if (link.dn_valid && link.dn_type == DN_IREQ) begin
      inv_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      v_r <= '0;
      for (int i = 0; i < CREDITS; i++) begin
        idx_r[i] <= '0;
        asid_r[i] <= '0;
      end
      inv_r <= 1'b0;
      up_v_r <= 1'b0;
      up_t_r <= 1'b0;
      up_i_r <= '0;
      up_a_r <= '0;
      up_l_r <= 1'b0;
      rv_r <= 1'b0;
      ri_r <= '0;
      ra_r <= '0;
      rc_r <= '0;
    end else if (en_i) begin
      v_r <= v_nxt;
      idx_r <= idx_nxt;
      asid_r <= asid_nxt;
      inv_r <= inv_nxt;
      up_v_r <= up_v_nxt;
      up_t_r <= up_t_nxt;
      up_i_r <= up_i_nxt;
      up_a_r <= up_a_nxt;
      up_l_r <= up_l_nxt;
      rv_r <= rv_nxt;
      ri_r <= ri_nxt;
      ra_r <= ra_nxt;
      rc_r <= rc_nxt;
    end
  end

  assign fault_ready_o = found;
  assign qry_busy_o = busy;
  assign credits_o = nfree;
  assign link.up_valid = up_v_r;
  assign link.up_type = up_t_r;
  assign link.up_index = up_i_r;
  assign link.up_asid = up_a_r;
  assign link.up_last = up_l_r;
  assign resp_valid_o = rv_r;
  assign resp_index_o = ri_r;
  assign resp_asid_o = ra_r;
  assign resp_code_o = rc_r;
endmodule
`default_nettype wire

// >>> hw/prdc_link_if.sv
`timescale 1ns/10ps
`default_nettype none
// one posted channel each way keeps strict ordering
interface prdc_link_if;
  logic up_valid;
  logic up_type;
  logic [prdc_pkg::IDX_W-1:0] up_index;
  logic [prdc_pkg::ASID_W-1:0] up_asid;
  logic up_last;
  logic dn_valid;
  logic dn_type;
  logic [prdc_pkg::IDX_W-1:0] dn_index;
  logic [prdc_pkg::ASID_W-1:0] dn_asid;
  logic [prdc_pkg::CODE_W-1:0] dn_code;

  modport ep (
    output up_valid, up_type, up_index, up_asid, up_last,
    input dn_valid, dn_type, dn_index, dn_asid, dn_code
  );
  modport rmu (
    input up_valid, up_type, up_index, up_asid, up_last,
    output dn_valid, dn_type, dn_index, dn_asid, dn_code
  );
endinterface
`default_nettype wire

// >>> hw/prdc_pkg.sv
package prdc_pkg;
  localparam int IDX_W = 9;
  localparam int ASID_W = 8;
  localparam int CODE_W = 4;
  localparam int CREDITS = 4;
  localparam int SLOT_W = 2;
  localparam int PRQ_DEPTH = 4;
  localparam int CNT_W = 3;
  localparam int ADDR_W = 5;
  localparam int STAT_W = 3;

  localparam logic UP_PREQ = 1'h0;
  localparam logic UP_ICPL = 1'h1;
  localparam logic DN_RESP = 1'h0;
  localparam logic DN_IREQ = 1'h1;
  localparam logic [CODE_W-1:0] RC_SUCCESS = 4'h0;

  localparam logic [ADDR_W-1:0] OFS_CTRL = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_RESP = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_STAT = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_MASK = 5'h0C;
  localparam logic [ADDR_W-1:0] OFS_PRQ = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_INFO = 5'h14;

  localparam int CTRL_START = 0;
  localparam int CTRL_SEL = 1;
  localparam int CTRL_ASID_LSB = 8;
  localparam int CTRL_BUSY = 31;
  localparam int RESP_IDX_LSB = 0;
  localparam int RESP_ASID_LSB = 16;
  localparam int RESP_CODE_LSB = 24;
  localparam int PRQ_IDX_LSB = 0;
  localparam int PRQ_ASID_LSB = 16;
  localparam int PRQ_LAST = 30;
  localparam int PRQ_VALID = 31;
  localparam int INFO_CNT_LSB = 0;
  localparam int INFO_STATE_LSB = 8;
  localparam int INFO_RESP_BUSY = 16;
  localparam int STAT_DONE = 0;
  localparam int STAT_OVF = 1;
  localparam int STAT_PREQ = 2;
  localparam logic [STAT_W-1:0] MASK_RST = 3'h0;

  typedef enum logic [4:0] {
    DR_IDLE = 5'h01,
    DR_FENCE = 5'h02,
    DR_INV = 5'h04,
    DR_WAIT = 5'h08,
    DR_STAT = 5'h10
  } prdc_drain_t;
endpackage

// >>> hw/prdc_remap.sv
`timescale 1ns/10ps
`default_nettype none
module prdc_remap (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic en_i,
  prdc_link_if.rmu link,
  input wire logic [prdc_pkg::ADDR_W-1:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output logic irq_o
);
  import prdc_pkg::*;

  prdc_drain_t st_r, st_nxt;
  logic sel_r, sel_nxt, ovfd_r, ovfd_nxt;
  logic [ASID_W-1:0] dasid_r, dasid_nxt;
  logic [IDX_W-1:0] qi_r [PRQ_DEPTH];
  logic [IDX_W-1:0] qi_nxt [PRQ_DEPTH];
  logic [ASID_W-1:0] qa_r [PRQ_DEPTH];
  logic [ASID_W-1:0] qa_nxt [PRQ_DEPTH];
  logic [PRQ_DEPTH-1:0] ql_r, ql_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt, k;
  logic auto_r, auto_nxt, sw_r, sw_nxt;
  logic [IDX_W-1:0] ai_r, ai_nxt, si_r, si_nxt;
  logic [ASID_W-1:0] aa_r, aa_nxt, sa_r, sa_nxt;
  logic [CODE_W-1:0] sc_r, sc_nxt;
  logic dv_r, dv_nxt, dt_r, dt_nxt;
  logic [IDX_W-1:0] di_r, di_nxt;
  logic [ASID_W-1:0] da_r, da_nxt;
  logic [CODE_W-1:0] dc_r, dc_nxt;
  logic [STAT_W-1:0] stat_r, stat_nxt, mask_r, mask_nxt, sset, sclr;
  logic [31:0] rd_r, rd_nxt;
  logic pop, disc, keep, preq, icpl;

  function automatic logic wr_at(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    return a == ofs;
  endfunction

  assign preq = link.up_valid && link.up_type == UP_PREQ;
  assign icpl = link.up_valid && link.up_type == UP_ICPL;

  always_comb begin
    st_nxt = st_r;
    sel_nxt = sel_r;
    dasid_nxt = dasid_r;
    ovfd_nxt = ovfd_r;
    qi_nxt = qi_r;
    qa_nxt = qa_r;
    ql_nxt = ql_r;
    auto_nxt = auto_r;
    ai_nxt = ai_r;
    aa_nxt = aa_r;
    sw_nxt = sw_r;
    si_nxt = si_r;
    sa_nxt = sa_r;
    sc_nxt = sc_r;
    dv_nxt = 1'b0;
    dt_nxt = dt_r;
    di_nxt = di_r;
    da_nxt = da_r;
    dc_nxt = dc_r;
    sset = '0;
    disc = 1'b0;
    keep = 1'b0;
    k = '0;
    pop = rd_i && wr_at(addr_i, OFS_PRQ) && cnt_r != '0;

    // downstream arbiter: responses always precede the invalidation
    if (auto_r) begin
      dv_nxt = 1'b1;
      dt_nxt = DN_RESP;
      di_nxt = ai_r;
      da_nxt = aa_r;
      dc_nxt = RC_SUCCESS;
      auto_nxt = 1'b0;
    end else if (sw_r) begin
      dv_nxt = 1'b1;
      dt_nxt = DN_RESP;
      di_nxt = si_r;
      da_nxt = sa_r;
      dc_nxt = sc_r;
      sw_nxt = 1'b0;
    end else if (st_r == DR_INV) begin
      dv_nxt = 1'b1;
      dt_nxt = DN_IREQ;
      st_nxt = DR_WAIT;
    end

    case (st_r)
      DR_IDLE: begin
        if (wr_i && wr_at(addr_i, OFS_CTRL) && wdata_i[CTRL_START]) begin
          st_nxt = DR_FENCE;
          sel_nxt = wdata_i[CTRL_SEL];
          dasid_nxt = wdata_i[CTRL_ASID_LSB +: ASID_W];
          ovfd_nxt = 1'b0;
        end
      end
      DR_FENCE: begin
        if (!auto_r && !sw_r) begin
          st_nxt = DR_INV;
        end
      end
      DR_INV: begin
      end
      DR_WAIT: begin
        if (icpl) begin
          st_nxt = DR_STAT;
        end
      end
      DR_STAT: begin
        // earlier requests already sit in the queue: one channel, in order
        if (ovfd_r) begin
          ovfd_nxt = 1'b0;
          st_nxt = DR_INV;
        end else begin
          disc = 1'b1;
          sset[STAT_DONE] = 1'b1;
          st_nxt = DR_IDLE;
        end
      end
      default: begin
        st_nxt = DR_IDLE;
      end
    endcase

    // queue compaction handles pop and selective discard in one pass
    for (int i = 0; i < PRQ_DEPTH; i++) begin
      keep = CNT_W'(i) < cnt_r && !(pop && i == 0) && !(disc && (!sel_r || qa_r[i] == dasid_r));
      if (keep) begin
        qi_nxt[k[SLOT_W-1:0]] = qi_r[i];
        qa_nxt[k[SLOT_W-1:0]] = qa_r[i];
        ql_nxt[k[SLOT_W-1:0]] = ql_r[i];
        k = k + 1'b1;
      end
    end
    cnt_nxt = k;
    if (preq) begin
      sset[STAT_PREQ] = 1'b1;
      if (k == CNT_W'(PRQ_DEPTH)) begin
        sset[STAT_OVF] = 1'b1;
        if (st_r != DR_IDLE) begin
          ovfd_nxt = 1'b1;
        end
        if (link.up_last) begin
          auto_nxt = 1'b1;
          ai_nxt = link.up_index;
          aa_nxt = link.up_asid;
        end
      end else begin
        qi_nxt[k[SLOT_W-1:0]] = link.up_index;
        qa_nxt[k[SLOT_W-1:0]] = link.up_asid;
        ql_nxt[k[SLOT_W-1:0]] = link.up_last;
        cnt_nxt = k + 1'b1;
      end
    end

    // a response written while sw_r holds one back replaces it
    if (wr_i && wr_at(addr_i, OFS_RESP)) begin
      sw_nxt = 1'b1;
      si_nxt = wdata_i[RESP_IDX_LSB +: IDX_W];
      sa_nxt = wdata_i[RESP_ASID_LSB +: ASID_W];
      sc_nxt = wdata_i[RESP_CODE_LSB +: CODE_W];
    end
  end

  always_comb begin
    sclr = (wr_i && wr_at(addr_i, OFS_STAT)) ? wdata_i[STAT_W-1:0] : '0;
    stat_nxt = (stat_r & ~sclr) | sset;
    mask_nxt = (wr_i && wr_at(addr_i, OFS_MASK)) ? wdata_i[STAT_W-1:0] : mask_r;
    rd_nxt = '0;
    if (rd_i) begin
      case (addr_i)
        OFS_CTRL: begin
          rd_nxt[CTRL_SEL] = sel_r;
          rd_nxt[CTRL_ASID_LSB +: ASID_W] = dasid_r;
          rd_nxt[CTRL_BUSY] = st_r != DR_IDLE;
        end
        OFS_STAT: rd_nxt[STAT_W-1:0] = stat_r;
        OFS_MASK: rd_nxt[STAT_W-1:0] = mask_r;
        OFS_PRQ: begin
          if (cnt_r != '0) begin
            rd_nxt[PRQ_VALID] = 1'b1;
            rd_nxt[PRQ_LAST] = ql_r[0];
            rd_nxt[PRQ_ASID_LSB +: ASID_W] = qa_r[0];
            rd_nxt[PRQ_IDX_LSB +: IDX_W] = qi_r[0];
          end
        end
        OFS_INFO: begin
          rd_nxt[INFO_CNT_LSB +: CNT_W] = cnt_r;
          rd_nxt[INFO_STATE_LSB +: 5] = st_r;
          rd_nxt[INFO_RESP_BUSY] = sw_r | auto_r;
        end
        default: rd_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r <= DR_IDLE;
      sel_r <= 1'b0;
      dasid_r <= '0;
      ovfd_r <= 1'b0;
      for (int i = 0; i < PRQ_DEPTH; i++) begin
        qi_r[i] <= '0;
        qa_r[i] <= '0;
      end
      ql_r <= '0;
      cnt_r <= '0;
      auto_r <= 1'b0;
      ai_r <= '0;
      aa_r <= '0;
      sw_r <= 1'b0;
      si_r <= '0;
      sa_r <= '0;
      sc_r <= '0;
      dv_r <= 1'b0;
      dt_r <= 1'b0;
      di_r <= '0;
      da_r <= '0;
      dc_r <= '0;
      stat_r <= '0;
      mask_r <= MASK_RST;
      rd_r <= '0;
    end else if (en_i) begin
      st_r <= st_nxt;
      sel_r <= sel_nxt;
      dasid_r <= dasid_nxt;
      ovfd_r <= ovfd_nxt;
      qi_r <= qi_nxt;
      qa_r <= qa_nxt;
      ql_r <= ql_nxt;
      cnt_r <= cnt_nxt;
      auto_r <= auto_nxt;
      ai_r <= ai_nxt;
      aa_r <= aa_nxt;
      sw_r <= sw_nxt;
      si_r <= si_nxt;
      sa_r <= sa_nxt;
      sc_r <= sc_nxt;
      dv_r <= dv_nxt;
      dt_r <= dt_nxt;
      di_r <= di_nxt;
      da_r <= da_nxt;
      dc_r <= dc_nxt;
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      rd_r <= rd_nxt;
    end
  end

  assign irq_o = |(stat_r & mask_r);
  assign rdata_o = rd_r;
  assign link.dn_valid = dv_r;
  assign link.dn_type = dt_r;
  assign link.dn_index = di_r;
  assign link.dn_asid = da_r;
  assign link.dn_code = dc_r;
endmodule
`default_nettype wire

// >>> verif/prdc_link_props.sv
`timescale 1ns/10ps
`default_nettype none
module prdc_link_props
  import prdc_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic up_valid,
  input wire logic up_type,
  input wire logic up_last,
  input wire logic dn_valid,
  input wire logic dn_type
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  logic inv;
  logic cpl;
  logic [2:0] pend_r;
  logic [2:0] pend_nxt;
  assign inv = dn_valid && dn_type == DN_IREQ;
  assign cpl = up_valid && up_type == UP_ICPL;
  // one completion answers every invalidation seen so far
  always_comb begin
    pend_nxt = (cpl ? 3'h0 : pend_r) + {2'h0, inv};
  end
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pend_r <= 3'h0;
    end else begin
      pend_r <= pend_nxt;
    end
  end
  a_inv_answered: assert property (inv |-> ##[1:16] cpl) else $error("invalidation not completed");
  a_cpl_has_inv: assert property (cpl |-> pend_r != 3'h0) else $error("completion without invalidation");
  a_cpl_no_last: assert property (cpl |-> !up_last) else $error("completion flagged last");
  a_quiet_release: assert property ($rose(nrst_i) |-> !up_valid && !dn_valid) else $error("link busy at release");
  a_cpl_merged: assert property (cpl && !inv |=> !cpl) else $error("duplicate completion");
  a_inv_single: assert property (pend_r <= 3'h1) else $error("second invalidation before completion");
  a_inv_spaced: assert property (inv |=> !inv [*2]) else $error("invalidations too close");
  a_up_next: assert property (inv |=> ##1 up_valid) else $error("no upstream message after invalidation");
  c_drain_cpl: cover property (inv ##1 cpl);
  c_req_last: cover property (up_valid && up_type == UP_PREQ && up_last);
  c_resp: cover property (dn_valid && dn_type == DN_RESP);
endmodule
`default_nettype wire

// >>> verif/test_page_request_drain_control.sv
`timescale 1ns/10ps
`default_nettype none
module test_page_request_drain_control;
  import prdc_pkg::*;
  logic clk_i, nrst_i, fv, fl, term, term_all, wr, rd, ready, busy, rv, irq;
  logic [IDX_W-1:0] fidx, ridx;
  logic [ASID_W-1:0] fasid, tasid, qasid, rasid;
  logic [CODE_W-1:0] rcode;
  logic [SLOT_W:0] credits;
  logic [ADDR_W-1:0] addr;
  logic [31:0] wdata, rdata, d;
  int n_errors, n_compared;
  logic en;
  int n_inv = 0;
  logic [31:0] q[$];
  logic [31:0] slot[5];
  bit pend[5];
  prdc_link_if link ();
  prdc_endpoint prdc_endpoint_i (.clk_i(clk_i), .nrst_i(nrst_i), .en_i(en), .link(link), .fault_valid_i(fv),
    .fault_index_i(fidx), .fault_asid_i(fasid), .fault_last_i(fl), .fault_ready_o(ready), .term_i(term),
    .term_all_i(term_all), .term_asid_i(tasid), .qry_asid_i(qasid), .qry_busy_o(busy), .credits_o(credits),
    .resp_valid_o(rv), .resp_index_o(ridx), .resp_asid_o(rasid), .resp_code_o(rcode));
  prdc_remap prdc_remap_i (.clk_i(clk_i), .nrst_i(nrst_i), .en_i(en), .link(link), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .irq_o(irq));
  prdc_link_props prdc_link_props_i (.clk_i(clk_i), .nrst_i(nrst_i), .up_valid(link.up_valid),
    .up_type(link.up_type), .up_last(link.up_last), .dn_valid(link.dn_valid), .dn_type(link.dn_type));
  // pre-edge value: one count per invalidation message
  always @(posedge clk_i) begin
    if (link.dn_valid === 1'b1 && link.dn_type === DN_IREQ) begin
      n_inv++;
    end
  end

  task automatic print_verdict();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr32(input logic [ADDR_W-1:0] a, input logic [31:0] v);
    @(posedge clk_i);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask
  task automatic rd32(input logic [ADDR_W-1:0] a, output logic [31:0] v);
    @(posedge clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic fault(input int i);
    @(posedge clk_i);
    fv <= 1'b1;
    fidx <= slot[i][8:0];
    fasid <= slot[i][23:16];
    fl <= slot[i][30];
    @(posedge clk_i);
    fv <= 1'b0;
  endtask
  task automatic wait_done();
    logic [31:0] s;
    s = 32'h0;
    for (int w = 0; w < 60 && s[0] !== 1'b1; w++) rd32(OFS_STAT, s);
    if (s[0] !== 1'b1) begin
      n_errors++;
      print_verdict();
    end
  endtask
  function automatic logic [31:0] rw(input logic [31:0] s);
    rw = {4'h0, RC_SUCCESS, s[23:16], 7'h00, s[8:0]};
  endfunction
  function automatic logic [31:0] npend();
    npend = 32'h0;
    foreach (pend[k]) npend += pend[k];
  endfunction
  // fixed window long enough for the slowest auto response path
  task automatic expect_resp(input logic [31:0] s, input bit hit);
    bit seen;
    seen = 1'b0;
    repeat (20) begin
      @(posedge clk_i);
      #1;
      if (rv === 1'b1) begin
        seen = 1'b1;
        chk({rcode, 4'h0, rasid, 7'h00, ridx}, {RC_SUCCESS, 4'h0, s[23:16], 7'h00, s[8:0]});
      end
    end
    chk({31'h0, seen}, {31'h0, hit});
    chk({29'h0, credits}, 32'h4 - npend());
  endtask
  task automatic terminate(input logic all, input logic [ASID_W-1:0] a);
    @(posedge clk_i);
    term <= 1'b1;
    term_all <= all;
    tasid <= a;
    qasid <= a;
    @(posedge clk_i);
    term <= 1'b0;
    #1;
    foreach (pend[k]) if (all || slot[k][23:16] == a) pend[k] = 0;
    chk({29'h0, credits}, 32'h4 - npend());
    chk({31'h0, busy}, 32'h0);
  endtask

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  initial begin
    {nrst_i, fv, fl, term, term_all, wr, rd} = '0;
    {fidx, fasid, tasid, qasid, addr, wdata} = '0;
    en = 1'b1;
    n_errors = 0;
    n_compared = 0;
    void'($urandom(52572));
    for (int i = 0; i < 5; i++) begin
      slot[i] = {1'b1, i != 1, 6'h00, 8'($urandom), 7'h00, 6'($urandom), i[2:0]};
    end
    repeat (12) @(posedge clk_i);
    nrst_i <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      fault(i);
      pend[i] = 1;
      q.push_back(slot[i]);
    end
    @(posedge clk_i);
    #1;
    chk({29'h0, credits}, 32'h0);
    chk({31'h0, ready}, 32'h0);
    $display("test fill done");
    rd32(OFS_STAT, d);
    chk(d & 32'h4, 32'h4);
    wr32(OFS_MASK, 32'h4);
    #1 chk({31'h0, irq}, 32'h1);
    wr32(OFS_STAT, 32'h4);
    #1 chk({31'h0, irq}, 32'h0);
    $display("test irq done");
    wr32(OFS_RESP, rw(slot[0]));
    pend[0] = 0;
    expect_resp(slot[0], 1'b1);
    // queue still holds four entries, so this one overflows
    fault(4);
    expect_resp(slot[4], 1'b1);
    rd32(OFS_STAT, d);
    chk(d & 32'h2, 32'h2);
    $display("test overflow done");
    terminate(1'b0, slot[1][23:16]);
    wr32(OFS_RESP, rw(slot[1]));
    expect_resp(slot[1], 1'b0);
    $display("test terminal done");
    wr32(OFS_CTRL, {16'h0, slot[2][23:16], 6'h00, 2'h3});
    wait_done();
    q = q.find(e) with (e[23:16] != slot[2][23:16]);
    rd32(OFS_INFO, d);
    chk(d & 32'h7, q.size());
    foreach (q[k]) begin
      rd32(OFS_PRQ, d);
      chk(d, q[k]);
    end
    rd32(OFS_PRQ, d);
    chk(d, 32'h0);
    $display("test drain done");
    chk(n_inv, 32'h1);
    // frozen: an offered fault must not take a credit
    @(posedge clk_i);
    en <= 1'b0;
    fault(0);
    #1 chk({29'h0, credits}, 32'h4 - npend());
    @(posedge clk_i);
    en <= 1'b1;
    $display("test freeze done");
    terminate(1'b1, 8'h00);
    for (int i = 0; i < 4; i++) begin
      fault(i);
      pend[i] = 1;
    end
    wr32(OFS_RESP, rw(slot[0]));
    pend[0] = 0;
    expect_resp(slot[0], 1'b1);
    wr32(OFS_STAT, 32'h7);
    wr32(OFS_CTRL, 32'h1);
    // full queue mid-drain forces a second invalidation pass
    fault(4);
    wait_done();
    chk(n_inv, 32'h3);
    rd32(OFS_STAT, d);
    chk(d & 32'h2, 32'h2);
    rd32(OFS_INFO, d);
    chk(d & 32'h7, 32'h0);
    rd32(OFS_PRQ, d);
    chk(d, 32'h0);
    chk({29'h0, credits}, 32'h4 - npend());
    $display("test drain repeat done");
    terminate(1'b1, 8'h00);
    rd32(5'h1C, d);
    chk(d, 32'h0);
    $display("test cancel all done");
    print_verdict();
  end
endmodule
`default_nettype wire
